// ### hdl/bank_switch_control.v
// Bank-switch control register with external bus sequencing and APB slave
//
// Implementation choices: the register offsets and the APB interface to the registers.
`timescale 1ns/1ps
`include "bank_switch_regs.vh"
module bank_switch_control (
  // Clock and reset
  input  wire        sys_clk,
  input  wire        rst,
  // APB slave
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [11:0] paddr,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output reg         pready,
  output reg         pslverr,
  // Subsystem select pin and other copy of the control register
  input  wire        subsystem_select,
  input  wire [15:0] other_bank_switch_control,
  // External access requests from the core
  input  wire        acc_req,
  input  wire [1:0]  acc_kind,
  input  wire [17:0] acc_addr,
  output reg         acc_gap,
  output reg         acc_start,
  // External pins
  output reg  [17:0] ext_addr,
  output reg         ext_ctrl_active,
  input  wire [15:0] ext_data_bus_in,
  output reg  [15:0] ext_data_bus_out,
  output reg         ext_data_bus_oe,
  input  wire [15:0] core_wdata,
  // Mode bits guarded while bus off
  output reg         data_rom_enable,
  output reg         micro_mode_select,
  output reg         ram_overlay_enable,
  output reg         hold_mode,
  // Interrupts
  output reg         interproc_irq_out,
  output reg         irq
);
  localparam ST_IDLE = 2'h0;
  localparam ST_GAP  = 2'h1;
  localparam ST_BUSY = 2'h2;
  localparam ST_OFF  = 2'h3;

  reg  [15:0] bank_switch_control_r;
  reg  [`IRQ_W-1:0] irq_status_r;
  reg  [`IRQ_W-1:0] irq_mask_r;
  reg  [1:0]  state_r;
  reg  [17:0] prev_addr_r;
  reg  [1:0]  prev_kind_r;
  reg         prev_valid_r;
  reg  [15:0] holder_r;
  reg         ipi_prev_r;
  reg  [1:0]  pend_kind_r;
  reg  [17:0] pend_addr_r;
  wire        sel_b_sync;
  wire [15:0] data_sync;

  sel_sync #(.W(1)) u_sel_sync (
    .sys_clk (sys_clk),
    .rst     (rst),
    .d       (subsystem_select),
    .q       (sel_b_sync)
  );

  sel_sync #(.W(16)) u_data_sync (
    .sys_clk (sys_clk),
    .rst     (rst),
    .d       (ext_data_bus_in),
    .q       (data_sync)
  );

  wire [15:0] gov = sel_b_sync ? other_bank_switch_control : bank_switch_control_r;
  // bank mask: four-bit mask only, so 4K..64K by construction
  wire [3:0]  bmask = gov[`BNK_HI:`BNK_LO];
  wire        bus_off = gov[`BUS_OFF_BIT];

  wire bank_cross = prev_valid_r &&
                    (((acc_addr[15:12] ^ prev_addr_r[15:12]) & bmask) != 4'h0);
  wire page_cross = prev_valid_r && (acc_kind == `KIND_PROG_RD) &&
                    (prev_kind_r == `KIND_PROG_RD) &&
                    (acc_addr[17:16] != prev_addr_r[17:16]);
  wire pd_turn = prev_valid_r && gov[`PD_GAP_BIT] &&
                 (((acc_kind == `KIND_PROG_RD) && (prev_kind_r == `KIND_DATA_RD)) ||
                  ((acc_kind == `KIND_DATA_RD) && (prev_kind_r == `KIND_PROG_RD)));
  wire need_gap = bank_cross || page_cross || pd_turn;

  wire apb_acc  = psel && penable && !pready;
  wire apb_wr   = apb_acc && pwrite;
  wire apb_rd   = apb_acc && !pwrite;
  wire mapped   = (paddr == `OFF_BANK_SWITCH_CONTROL) || (paddr == `OFF_IRQ_STATUS) ||
                  (paddr == `OFF_IRQ_MASK) || (paddr == `OFF_BUS_STATE) ||
                  (paddr == `OFF_MODE_CONTROL);
  wire ipi_rise = bank_switch_control_r[`IPI_BIT] && !ipi_prev_r;
  wire off_evt  = (state_r != ST_OFF) && bus_off && (state_r == ST_IDLE);
  wire [`IRQ_W-1:0] irq_set;
  assign irq_set[`IRQ_IPI_BIT]   = ipi_rise;
  assign irq_set[`IRQ_CROSS_BIT] = acc_start && acc_gap;
  assign irq_set[`IRQ_OFF_BIT]   = off_evt;

  // APB register side
  always @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      bank_switch_control_r <= `BSC_RESET;
      irq_mask_r            <= {`IRQ_W{1'b0}};
      irq_status_r          <= {`IRQ_W{1'b0}};
      prdata                <= 32'h0000_0000;
      pready                <= 1'b0;
      pslverr               <= 1'b0;
      data_rom_enable       <= 1'b0;
      micro_mode_select     <= 1'b0;
      ram_overlay_enable    <= 1'b0;
      hold_mode             <= 1'b0;
    end else begin
      pready  <= apb_acc;
      pslverr <= apb_acc && !mapped;
      if (apb_wr && paddr == `OFF_BANK_SWITCH_CONTROL) begin
        bank_switch_control_r <= pwdata[15:0] & `BSC_WRITE_MASK;
      end
      if (apb_wr && paddr == `OFF_IRQ_MASK)
        irq_mask_r <= pwdata[`IRQ_W-1:0];
      // mode bits frozen while bus off
      if (apb_wr && paddr == `OFF_MODE_CONTROL && !bus_off) begin
        data_rom_enable    <= pwdata[0];
        micro_mode_select  <= pwdata[1];
        ram_overlay_enable <= pwdata[2];
        hold_mode          <= pwdata[3];
      end
      // Set wins over read-clear
      if (apb_rd && paddr == `OFF_IRQ_STATUS)
        irq_status_r <= irq_set;
      else
        irq_status_r <= irq_status_r | irq_set;
      if (apb_rd) begin
        case (paddr)
          `OFF_BANK_SWITCH_CONTROL: prdata <= {16'h0000, bank_switch_control_r};
          `OFF_IRQ_STATUS:          prdata <= {29'h0, irq_status_r};
          `OFF_IRQ_MASK:            prdata <= {29'h0, irq_mask_r};
          `OFF_BUS_STATE:           prdata <= {27'h0, sel_b_sync, state_r, ext_data_bus_oe,
                                               ext_ctrl_active};
          `OFF_MODE_CONTROL:        prdata <= {28'h0, hold_mode, ram_overlay_enable,
                                               micro_mode_select, data_rom_enable};
          default:                  prdata <= 32'h0000_0000;
        endcase
      end
    end
  end

  // Interprocessor request edge and interrupt output
  always @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      ipi_prev_r        <= 1'b0;
      interproc_irq_out <= 1'b0;
      irq               <= 1'b0;
    end else begin
      ipi_prev_r        <= bank_switch_control_r[`IPI_BIT];
      // one pulse per rising edge; bit must drop before next
      interproc_irq_out <= ipi_rise;
      irq               <= |((irq_status_r | irq_set) & irq_mask_r);
    end
  end

  // External bus sequencer
  always @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      state_r          <= ST_IDLE;
      prev_addr_r      <= 18'h00000;
      prev_kind_r      <= `KIND_DATA_RD;
      prev_valid_r     <= 1'b0;
      pend_addr_r      <= 18'h00000;
      pend_kind_r      <= `KIND_DATA_RD;
      acc_gap          <= 1'b0;
      acc_start        <= 1'b0;
      ext_addr         <= 18'h00000;
      ext_ctrl_active  <= 1'b0;
      ext_data_bus_out <= 16'h0000;
      ext_data_bus_oe  <= 1'b0;
      holder_r         <= 16'h0000;
    end else begin
      acc_start <= 1'b0;
      acc_gap   <= 1'b0;
      if (ext_data_bus_oe)
        holder_r <= ext_data_bus_out;
      else
        holder_r <= data_sync;
      case (state_r)
        ST_IDLE: begin
          ext_ctrl_active <= 1'b0;
          ext_data_bus_oe <= 1'b0;
          if (bus_off) begin
            state_r <= ST_OFF;
          end else if (acc_req) begin
            pend_addr_r <= acc_addr;
            pend_kind_r <= acc_kind;
            if (need_gap) begin
              state_r <= ST_GAP;
              acc_gap <= 1'b1;
            end else begin
              state_r         <= ST_BUSY;
              acc_start       <= 1'b1;
              ext_addr        <= acc_addr;
              ext_ctrl_active <= 1'b1;
              ext_data_bus_oe <= (acc_kind == `KIND_WRITE);
              ext_data_bus_out <= core_wdata;
            end
          end else if (gov[`HOLDER_BIT]) begin
            ext_data_bus_out <= holder_r;
          end
        end
        ST_GAP: begin
          state_r         <= ST_BUSY;
          acc_start       <= 1'b1;
          acc_gap         <= 1'b1;
          ext_addr        <= pend_addr_r;
          ext_ctrl_active <= 1'b1;
          ext_data_bus_oe <= (pend_kind_r == `KIND_WRITE);
          ext_data_bus_out <= core_wdata;
        end
        ST_BUSY: begin
          // current cycle completes before going off
          prev_addr_r     <= ext_addr;
          prev_kind_r     <= pend_kind_r;
          prev_valid_r    <= 1'b1;
          ext_ctrl_active <= 1'b0;
          ext_data_bus_oe <= 1'b0;
          state_r         <= ST_IDLE;
        end
        ST_OFF: begin
          ext_addr         <= 18'h00000;
          ext_ctrl_active  <= 1'b0;
          ext_data_bus_oe  <= 1'b0;
          ext_data_bus_out <= 16'h0000;
          prev_valid_r     <= 1'b0;
          if (!bus_off)
            state_r <= ST_IDLE;
        end
        default: state_r <= ST_IDLE;
      endcase
      if (state_r == ST_IDLE && !acc_req)
        pend_kind_r <= pend_kind_r;
    end
  end
endmodule

// ### hdl/bank_switch_regs.vh
// Register offsets, field positions, reset values and access kind codes for the bank-switch control block
`ifndef BANK_SWITCH_REGS_VH
`define BANK_SWITCH_REGS_VH

`define OFF_BANK_SWITCH_CONTROL 12'h000
`define OFF_IRQ_STATUS          12'h004
`define OFF_IRQ_MASK            12'h008
`define OFF_BUS_STATE           12'h00c
`define OFF_MODE_CONTROL        12'h010

`define BSC_RESET               16'hf800
`define BSC_WRITE_MASK          16'hf905
`define BNK_HI                  15
`define BNK_LO                  12
`define PD_GAP_BIT              11
`define IPI_BIT                 8
`define HOLDER_BIT              2
`define BUS_OFF_BIT             0

`define MODE_RESET              4'h0
`define IRQ_IPI_BIT             0
`define IRQ_CROSS_BIT           1
`define IRQ_OFF_BIT             2
`define IRQ_W                   3

`define KIND_DATA_RD            2'h0
`define KIND_PROG_RD            2'h1
`define KIND_WRITE              2'h2
`define KIND_IO                 2'h3

`endif

// ### hdl/sel_sync.v
// Two-flop synchroniser for level inputs arriving from pins
`timescale 1ns/1ps
module sel_sync #(
  parameter W = 1
) (
  // Clock and reset
  input  wire         sys_clk,
  input  wire         rst,
  // Level in and out
  input  wire [W-1:0] d,
  output reg  [W-1:0] q
);
  reg [W-1:0] meta_r;

  always @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      meta_r <= {W{1'b0}};
      q      <= {W{1'b0}};
    end else begin
      meta_r <= d;
      q      <= meta_r;
    end
  end
endmodule

// ### testbench/bank_switch_control_properties.sv
// Port checks for the bank-switch control block
`timescale 1ns/1ps
module bank_switch_control_properties (
  // Clock and reset
  input wire logic        sys_clk,
  input wire logic        rst,
  // Observed ports
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        acc_start,
  input wire logic        acc_gap,
  input wire logic        ext_ctrl_active,
  input wire logic [17:0] acc_addr,
  input wire logic [17:0] ext_addr,
  input wire logic        interproc_irq_out
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (rst);
  property p_ready_wait; psel && penable && !pready |=> pready; endproperty
  a_ready_wait: assert property (p_ready_wait) else $error("pready late");
  property p_ready_pulse; pready |=> !pready; endproperty
  a_ready_pulse: assert property (p_ready_pulse) else $error("pready held");
  property p_err_ready; pslverr |-> pready; endproperty
  a_err_ready: assert property (p_err_ready) else $error("pslverr alone");
  property p_ctrl_one; ext_ctrl_active |=> !ext_ctrl_active; endproperty
  a_ctrl_one: assert property (p_ctrl_one) else $error("ctrl too long");
  property p_ctrl_start; $rose(ext_ctrl_active) |-> acc_start; endproperty
  a_ctrl_start: assert property (p_ctrl_start) else $error("ctrl w/o start");
  property p_addr; acc_start |-> ext_addr == acc_addr; endproperty
  a_addr: assert property (p_addr) else $error("address wrong");
  property p_gap_start; acc_gap && !acc_start |=> acc_start && acc_gap; endproperty
  a_gap_start: assert property (p_gap_start) else $error("no start after gap");
  property p_gap_prior; acc_start && acc_gap |-> $past(acc_gap); endproperty
  a_gap_prior: assert property (p_gap_prior) else $error("gap not inserted");
  property p_ipi_pulse; interproc_irq_out |=> !interproc_irq_out; endproperty
  a_ipi_pulse: assert property (p_ipi_pulse) else $error("ipi held");
endmodule
bind bank_switch_control bank_switch_control_properties u_props (.*);

// ### testbench/ext_mem_model.sv
// External memory on the bus: returns address-based data
`timescale 1ns/1ps
module ext_mem_model (
  // Clock and reset
  input  wire logic        sys_clk,
  input  wire logic        rst,
  // Bus from the block
  input  wire logic        ext_ctrl_active,
  input  wire logic        ext_data_bus_oe,
  input  wire logic [17:0] ext_addr,
  output logic      [15:0] ext_data_bus_in
);
  // Released bus toggles so a stale word never passes for data
  always @(posedge sys_clk or posedge rst) begin
    if (rst)
      ext_data_bus_in <= 16'h0000;
    else if (ext_ctrl_active && !ext_data_bus_oe)
      ext_data_bus_in <= ext_addr[15:0];
    else
      ext_data_bus_in <= ~ext_data_bus_in;
  end
endmodule

// ### testbench/tb_top.sv
// Self-checking bench for the bank-switch control block
`timescale 1ns/1ps
module tb_top;
  logic        sys_clk, rst, psel, penable, pwrite, pready, pslverr, irq, rerr;
  logic        subsystem_select, acc_req, acc_gap, acc_start, ext_ctrl_active;
  logic        ext_data_bus_oe, data_rom_enable, micro_mode_select;
  logic        ram_overlay_enable, hold_mode, interproc_irq_out;
  logic [1:0]  acc_kind;
  logic [11:0] paddr;
  logic [15:0] other_bank_switch_control, ext_data_bus_in, ext_data_bus_out, core_wdata;
  logic [17:0] acc_addr, ext_addr;
  logic [31:0] pwdata, prdata, rdat;
  int          error_cnt, tests_run, ipi_cnt, cyc;
  bank_switch_control u_dut (.*);
  ext_mem_model u_mem (.*);
  initial begin
    sys_clk = 0;
    forever #4 sys_clk = ~sys_clk;
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      error_cnt++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    @(posedge sys_clk);
    psel <= 1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge sys_clk);
    penable <= 1;
    n = 0;
    do begin
      @(posedge sys_clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    // A slave that never answers is a mismatch, not a silent pass
    if (pready !== 1'b1) begin
      error_cnt++;
      $display("unexpected at %0t: no pready", $time);
    end
    rdat = prdata;
    rerr = pslverr;
    psel <= 0;
    penable <= 0;
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(1, a, d);
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] e);
    apb(0, a, 0);
    chk(rdat, e);
  endtask
  // g: 0 no gap, 1 gap, 2 either, 3 refused
  task automatic acc(input logic [1:0] k, input logic [17:0] a, input int g);
    int n;
    logic sg;
    @(posedge sys_clk);
    acc_req <= 1;
    acc_kind <= k;
    acc_addr <= a;
    sg = 0;
    n = 0;
    do begin
      @(posedge sys_clk);
      n++;
      sg |= acc_gap;
    end while (acc_start !== 1'b1 && n < 10);
    acc_req <= 0;
    chk(acc_start, g != 3);
    if (g < 2) chk(sg, g);
    if (g != 3) chk(ext_data_bus_oe, k == 2);
    if (g != 3 && k == 2) chk(ext_data_bus_out, core_wdata);
  endtask
  task automatic close_out;
    $display("errors %0d, checks %0d", error_cnt, tests_run);
    if (error_cnt == 0 && tests_run > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
    if (interproc_irq_out === 1'b1) ipi_cnt <= ipi_cnt + 1;
    if (cyc == 3000) begin
      error_cnt++;
      close_out();
    end
  end
  initial begin
    rst = 1;
    {psel, penable, pwrite, paddr, pwdata, subsystem_select} = '0;
    {acc_req, acc_kind, acc_addr, other_bank_switch_control} = '0;
    core_wdata = 16'h5a5a;
    repeat (2) @(posedge sys_clk);
    rst <= 0;
    rd(12'h000, 32'hf800);
    wr(12'h000, 32'hfefe);
    rd(12'h000, 32'hf804);
    rd(12'h020, 32'h0);
    chk(rerr, 1);
    wr(12'h000, 32'hf000);
    acc(0, 18'h01000, 2);
    acc(0, 18'h02000, 1);
    acc(0, 18'h02fff, 0);
    wr(12'h000, 32'h0);
    acc(0, 18'h05000, 0);
    acc(1, 18'h05000, 0);
    acc(1, 18'h15000, 1);
    wr(12'h000, 32'h0800);
    acc(0, 18'h15000, 1);
    acc(1, 18'h15000, 1);
    acc(1, 18'h15000, 0);
    subsystem_select <= 1;
    wr(12'h000, 32'hf000);
    acc(0, 18'h01000, 0);
    subsystem_select <= 0;
    repeat (3) @(posedge sys_clk);
    acc(0, 18'h02000, 1);
    acc(2, 18'h02010, 0);
    wr(12'h000, 32'h1);
    acc(0, 18'h00000, 3);
    wr(12'h010, 32'hf);
    rd(12'h010, 32'h0);
    wr(12'h000, 32'h0);
    wr(12'h010, 32'hf);
    rd(12'h010, 32'hf);
    chk(hold_mode, 1);
    apb(0, 12'h004, 0);
    wr(12'h008, 32'h1);
    wr(12'h000, 32'h100);
    repeat (3) @(posedge sys_clk);
    chk(ipi_cnt, 1);
    chk(irq, 1);
    rd(12'h004, 32'h1);
    repeat (2) @(posedge sys_clk);
    chk(irq, 0);
    wr(12'h000, 32'h100);
    wr(12'h000, 32'h0);
    wr(12'h000, 32'h100);
    repeat (3) @(posedge sys_clk);
    chk(ipi_cnt, 2);
    wr(12'h008, 32'h0);
    repeat (2) @(posedge sys_clk);
    chk(irq, 0);
    close_out();
  end
endmodule
